//--- design/incr_skip_and_or_literal.v
// Execution stage for increment_skip_if_zero, increment_skip_if_nonzero and or_literal_into_accumulator.
// Assumes one instruction presented per instruction cycle (instr_valid_i) and a
// file register operand read combinationally via file_rdata_i.
// Behaviour
// - Skip costs one or two no-op cycles
// - OR literal into accumulator only
// - Decode OR by upper byte, literal low
// - OR updates only negative and zero flags
`timescale 1ns/1ns
`default_nettype none
`include "incr_skip_defs.vh"
module incr_skip_and_or_literal (
	input wire mclk_i,
	input wire rst_n_i,
	input wire instr_valid_i,
	input wire [15:0] instr_i,
	input wire next_two_word_i,
	input wire [7:0] file_rdata_i,
	output reg [7:0] file_addr_o,
	output reg access_bank_o,
	output reg [7:0] file_wdata_o,
	output reg file_we_o,
	output reg [7:0] acc_o,
	output reg neg_o,
	output reg zero_o,
	output reg flags_we_o,
	output reg nop_o,
	output reg busy_o
);
	////////////////////////////////////////////////////////////////
	// Sequencer states; a skip walks through one or two flush states.
	localparam [1:0] ST_EXEC = 2'h0;
	localparam [1:0] ST_NOP1 = 2'h1;
	localparam [1:0] ST_NOP2 = 2'h2;

	// Operation classes handled by this block.
	localparam [1:0] OPC_NONE = 2'h0;
	localparam [1:0] OPC_INC_Z = 2'h1;
	localparam [1:0] OPC_INC_NZ = 2'h2;
	localparam [1:0] OPC_OR_LIT = 2'h3;

	reg [1:0] state_q;
	reg [1:0] state_d;
	reg [1:0] op_class;
	wire [5:0] top6;
	wire [7:0] top8;
	wire [7:0] operand;
	wire dest_is_file;
	wire bank_sel;
	wire taken;
	wire [7:0] inc_res;
	wire [7:0] or_res;
	wire or_neg;
	wire or_zero;
	wire inc_is_zero;
	wire do_skip;
	reg [7:0] file_addr_d;
	reg access_bank_d;
	reg [7:0] file_wdata_d;
	reg file_we_d;
	reg [7:0] acc_d;
	reg neg_d;
	reg zero_d;
	reg flags_we_d;
	reg nop_d;
	reg busy_d;

	////////////////////////////////////////////////////////////////
	// Instruction decode.
	assign top6 = instr_i[`OP6_MSB:`OP6_LSB];
	assign top8 = instr_i[`OP8_MSB:`OP8_LSB];
	assign operand = instr_i[`LIT_MSB:`LIT_LSB];
	assign dest_is_file = instr_i[`BIT_DEST];
	assign bank_sel = instr_i[`BIT_ACCESS];
	assign taken = instr_valid_i && (state_q == ST_EXEC);

	// The three opcode spaces do not overlap, so the order of the tests
	// below carries no priority meaning.
	always @* begin
		op_class = OPC_NONE;
		if (top6 == `OP_INCSZ_HI) begin
			op_class = OPC_INC_Z;
		end else if (top6 == `OP_INCSNZ_HI) begin
			op_class = OPC_INC_NZ;
		end else if (top8 == `OP_OR_LIT_HI) begin
			op_class = OPC_OR_LIT;
		end
	end

	////////////////////////////////////////////////////////////////
	// Data path: the increment wraps from all ones to zero by design.
	assign inc_res = file_rdata_i + `ONE_8;
	assign inc_is_zero = (inc_res == `ZERO_8);
	assign or_res = acc_o | operand;
	assign do_skip = ((op_class == OPC_INC_Z) && inc_is_zero) ||
		((op_class == OPC_INC_NZ) && !inc_is_zero);

	nz_flags u_flags (
		.value_i(or_res),
		.neg_o(or_neg),
		.zero_o(or_zero)
	);

	////////////////////////////////////////////////////////////////
	// The skipped word is already fetched, so it is flushed as a no-op; a
	// two-word successor needs a second flush cycle for its operand word.
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_EXEC: begin
				if (taken && do_skip) begin
					if (next_two_word_i) begin
						state_d = ST_NOP2;
					end else begin
						state_d = ST_NOP1;
					end
				end
			end
			ST_NOP2: begin
				state_d = ST_NOP1;
			end
			ST_NOP1: begin
				state_d = ST_EXEC;
			end
			default: begin
				state_d = ST_EXEC;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////
	// Next values of every output; held values stay put unless an accepted
	// instruction of this block writes them.
	always @* begin
		file_addr_d = file_addr_o;
		access_bank_d = access_bank_o;
		file_wdata_d = file_wdata_o;
		file_we_d = 1'h0;
		acc_d = acc_o;
		neg_d = neg_o;
		zero_d = zero_o;
		flags_we_d = 1'h0;
		nop_d = (state_q != ST_EXEC);
		busy_d = (state_d != ST_EXEC);
		if (taken) begin
			case (op_class)
				OPC_INC_Z, OPC_INC_NZ: begin
					// The increment pair leaves the status flags alone.
					if (dest_is_file) begin
						file_addr_d = operand;
						access_bank_d = bank_sel;
						file_wdata_d = inc_res;
						file_we_d = 1'h1;
					end else begin
						acc_d = inc_res;
					end
				end
				OPC_OR_LIT: begin
					acc_d = or_res;
					neg_d = or_neg;
					zero_d = or_zero;
					flags_we_d = 1'h1;
				end
				default: begin
					// Opcodes outside this block are left to the rest of the core.
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Sequencer register.
	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			state_q <= ST_EXEC;
		end else begin
			state_q <= state_d;
		end
	end

	// File write port; address and data stay valid after the strobe drops.
	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			file_addr_o <= `ZERO_8;
			access_bank_o <= 1'h0;
			file_wdata_o <= `ZERO_8;
			file_we_o <= 1'h0;
		end else begin
			file_addr_o <= file_addr_d;
			access_bank_o <= access_bank_d;
			file_wdata_o <= file_wdata_d;
			file_we_o <= file_we_d;
		end
	end

	// Working register and status flags.
	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			acc_o <= `ZERO_8;
			neg_o <= 1'h0;
			zero_o <= 1'h0;
		end else begin
			acc_o <= acc_d;
			neg_o <= neg_d;
			zero_o <= zero_d;
		end
	end

	// Single-cycle strobes and the flush indication.
	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			flags_we_o <= 1'h0;
			nop_o <= 1'h0;
			busy_o <= 1'h0;
		end else begin
			flags_we_o <= flags_we_d;
			nop_o <= nop_d;
			busy_o <= busy_d;
		end
	end
endmodule
`default_nettype wire

//--- design/incr_skip_defs.vh
// Constants for the increment-and-skip / OR-literal execution block.
// Assumes a 16-bit instruction word and 8-bit data path.
`ifndef INCR_SKIP_DEFS_VH
`define INCR_SKIP_DEFS_VH
`define OP_INCSZ_HI 6'h0F
`define OP_INCSNZ_HI 6'h12
`define OP_OR_LIT_HI 8'h09
`define OP6_MSB 15
`define OP6_LSB 10
`define OP8_MSB 15
`define OP8_LSB 8
`define BIT_DEST 9
`define BIT_ACCESS 8
`define LIT_MSB 7
`define LIT_LSB 0
`define ONE_8 8'h01
`define ZERO_8 8'h00
`endif

//--- design/nz_flags.v
// Negative/zero flag generator for an 8-bit result.
// Pure combinational; the caller registers the outputs.
`timescale 1ns/1ns
`default_nettype none
`include "incr_skip_defs.vh"
module nz_flags (
	input wire [7:0] value_i,
	output wire neg_o,
	output wire zero_o
);
	assign neg_o = value_i[`LIT_MSB];
	assign zero_o = (value_i == `ZERO_8);
endmodule
`default_nettype wire

//--- verification/incr_skip_chk_asserts.sv
// Port checker for the increment-skip and OR-literal block.
// Assumes a bind onto the design top; all names match its ports.
`timescale 1ns/1ns
`default_nettype none
module incr_skip_chk (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic instr_valid_i,
	input wire logic next_two_word_i,
	input wire logic [15:0] instr_i,
	input wire logic [7:0] file_rdata_i,
	input wire logic [7:0] file_wdata_o,
	input wire logic [7:0] acc_o,
	input wire logic file_we_o,
	input wire logic neg_o,
	input wire logic zero_o,
	input wire logic flags_we_o,
	input wire logic nop_o,
	input wire logic busy_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	wire t = instr_valid_i && !busy_o;
	wire [7:0] res = file_rdata_i + 8'h01;
	wire [7:0] or_exp = acc_o | instr_i[7:0];
	wire ti = t && (instr_i[15:10] == 6'h0F || instr_i[15:10] == 6'h12);
	wire sk = ti && ((res == 8'h00) != (instr_i[15:10] == 6'h12));
	wire tor = t && instr_i[15:8] == 8'h09;
	chk_or_result: assert property (tor |=> acc_o == $past(or_exp) && flags_we_o && !file_we_o)
		else $error("or result wrong");
	chk_or_flags: assert property (tor |=> neg_o == acc_o[7] && zero_o == (acc_o == 8'h00))
		else $error("or flags wrong");
	chk_flags_hold: assert property (!tor |=> !flags_we_o && $stable(neg_o) && $stable(zero_o))
		else $error("flags changed without or");
	chk_inc_write: assert property (ti && instr_i[9] |=> file_we_o && file_wdata_o == $past(res))
		else $error("increment write wrong");
	chk_skip_one: assert property (sk && !next_two_word_i |=> busy_o ##1 nop_o && !busy_o)
		else $error("single flush wrong");
	chk_skip_two: assert property (sk && next_two_word_i |=> busy_o ##1 nop_o ##1 nop_o && !busy_o)
		else $error("double flush wrong");
	chk_flush_quiet: assert property (busy_o |=> nop_o && !file_we_o && !flags_we_o)
		else $error("flush cycle did work");
	chk_no_skip: assert property (ti && !sk |=> !busy_o && !nop_o)
		else $error("unexpected flush");
	cover property (tor);
	cover property (sk && !next_two_word_i);
	cover property (sk && next_two_word_i);
endmodule
bind incr_skip_and_or_literal incr_skip_chk chk_u (
	.mclk_i(mclk_i),
	.rst_n_i(rst_n_i),
	.instr_valid_i(instr_valid_i),
	.next_two_word_i(next_two_word_i),
	.instr_i(instr_i),
	.file_rdata_i(file_rdata_i),
	.file_wdata_o(file_wdata_o),
	.acc_o(acc_o),
	.file_we_o(file_we_o),
	.neg_o(neg_o),
	.zero_o(zero_o),
	.flags_we_o(flags_we_o),
	.nop_o(nop_o),
	.busy_o(busy_o)
);
`default_nettype wire

//--- verification/tb.sv
// Random self-checking bench with an integer model of the block.
// Assumes the design top and its bound checker.
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic mclk_i = 0, rst_n_i = 0, instr_valid_i = 0, next_two_word_i = 0;
	logic [15:0] instr_i = 16'h0000;
	logic [7:0] file_rdata_i = 8'h00, file_addr_o, file_wdata_o, acc_o;
	logic access_bank_o, file_we_o, neg_o, zero_o, flags_we_o, nop_o, busy_o;
	int fail_count = 0, compares = 0, acc = 0, neg = 0, zero = 0;
	int pn, pw, po, wd, wa, wb, res, kind;
	// Each entry stands for one flush cycle still owed after a skip.
	int flush_q[$];
	bit [31:0] r;

	always #25 mclk_i = ~mclk_i;

	incr_skip_and_or_literal dut_u (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.instr_valid_i(instr_valid_i),
		.instr_i(instr_i),
		.next_two_word_i(next_two_word_i),
		.file_rdata_i(file_rdata_i),
		.file_addr_o(file_addr_o),
		.access_bank_o(access_bank_o),
		.file_wdata_o(file_wdata_o),
		.file_we_o(file_we_o),
		.acc_o(acc_o),
		.neg_o(neg_o),
		.zero_o(zero_o),
		.flags_we_o(flags_we_o),
		.nop_o(nop_o),
		.busy_o(busy_o)
	);

	task chk(input logic [7:0] s, input int e);
		compares++;
		if (s !== e[7:0]) begin
			fail_count++;
			$display("FAIL %0t seen %h expected %h", $time, s, e[7:0]);
		end
	endtask

	task wrap_up;
		if (fail_count == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	// Holds reset for n edges, checks accumulator, flags, strobes and flush outputs are cleared, then releases
	// it and clears the model, including any flush still owed.
	task do_reset(input int n);
		rst_n_i = 0;
		instr_valid_i = 0;
		repeat (n) @(posedge mclk_i);
		#2;
		chk(acc_o, 0);
		chk({zero_o, neg_o, flags_we_o}, 0);
		chk({nop_o, busy_o}, 0);
		chk(file_we_o, 0);
		rst_n_i = 1;
		acc = 0;
		neg = 0;
		zero = 0;
		flush_q.delete();
	endtask

	task step;
		r = $urandom;
		kind = r[3:2];
		{instr_valid_i, next_two_word_i} = r[21:20];
		file_rdata_i = r[1] ? 8'hFF : r[29:22];
		case (kind)
			0: instr_i = {6'h0F, r[19:10]};
			1: instr_i = {6'h12, r[19:10]};
			2: instr_i = {8'h09, r[17:10]};
			default: instr_i = {r[0] ? 8'h08 : 8'h3B, r[17:10]};
		endcase
		pn = flush_q.size() > 0;
		pw = 0;
		po = 0;
		if (flush_q.size() > 0) void'(flush_q.pop_front());
		else if (instr_valid_i) begin
			res = (file_rdata_i + 1) & 255;
			if (kind == 2) begin
				acc = acc | instr_i[7:0];
				neg = acc >> 7;
				zero = acc == 0;
				po = 1;
			end
			if (kind < 2) begin
				wd = res;
				wa = instr_i[7:0];
				wb = instr_i[8];
				if (instr_i[9]) pw = 1;
				else acc = res;
				if ((res == 0) != (kind == 1)) begin
					flush_q.push_back(1);
					if (next_two_word_i) flush_q.push_back(2);
				end
			end
		end
		@(posedge mclk_i);
		#2;
		chk(acc_o, acc);
		chk(file_we_o, pw);
		chk(nop_o, pn);
		chk(busy_o, flush_q.size() > 0);
		chk(flags_we_o, po);
		chk({zero_o, neg_o}, zero * 2 + neg);
		if (pw) begin
			chk(file_wdata_o, wd);
			chk(file_addr_o, wa);
			chk(access_bank_o, wb);
		end
	endtask

	initial begin
		void'($urandom(22051));
		do_reset(12);
		repeat (500) step();
		do_reset(3);
		repeat (500) step();
		wrap_up();
	end

	initial begin
		#100000;
		fail_count++;
		wrap_up();
	end
endmodule
`default_nettype wire
